// ### pkg/ffpc_defs.vh
// constants for the flat field pixel correction datapath
`ifndef FFPC_DEFS_VH
`define FFPC_DEFS_VH

// pixel stream
`define FFPC_PIX_W 12
`define FFPC_PIX_MAX 12'hfff
`define FFPC_TBL_AW 8
`define FFPC_TBL_DEPTH 256
`define FFPC_FIFO_DEPTH 8
`define FFPC_FIFO_AW 3

// apb byte offsets
`define FFPC_REG_CTRL 8'h00
`define FFPC_REG_CADDR 8'h04
`define FFPC_REG_CDATA 8'h08
`define FFPC_REG_FTA 8'h0c
`define FFPC_REG_FTB 8'h10
`define FFPC_REG_FTC 8'h14
`define FFPC_REG_OFSLO 8'h18
`define FFPC_REG_OFSHI 8'h1c
`define FFPC_REG_GAINHI 8'h20
`define FFPC_REG_GAINLO 8'h24
`define FFPC_REG_OFSMUL 8'h28
`define FFPC_REG_GDIV 8'h2c
`define FFPC_REG_STAT 8'h30

// control bits
`define FFPC_CTRL_W 6
`define FFPC_CTRL_OFS_EN 0
`define FFPC_CTRL_GAIN_EN 1
`define FFPC_CTRL_DEF_EN 2
`define FFPC_CTRL_FT_EN 3
`define FFPC_CTRL_GRES 4
`define FFPC_CTRL_CGRES 5
`define FFPC_CTRL_RST 6'h03

// status bits
`define FFPC_STAT_SAT 0
`define FFPC_STAT_LVL_LSB 8

// coefficient word layout
`define FFPC_OFS_MSB 6
`define FFPC_GAIN_LSB 7
`define FFPC_GAIN_MSB 15
`define FFPC_DEFECT_MARK 7'h7f

// read-only limits and scale figures
`define FFPC_OFS_LO 32'h00000001
`define FFPC_OFS_HI 32'h0000007e
`define FFPC_GAIN_HI 32'h000001fe
`define FFPC_GAIN_LO 32'h00000000
`define FFPC_OFS_MUL 32'h00000001
`define FFPC_GDIV_REPORT 32'h00000200
`define FFPC_BASE_HG 11'h200
`define FFPC_BASE_HR 11'h400
`define FFPC_SHIFT_HG 4'h9
`define FFPC_SHIFT_HR 4'ha
`define FFPC_FT_MAX 8'h7f
`define FFPC_FT_NEG_MIN 8'h80
`define FFPC_FT_NEG_LIM 8'h81
`define FFPC_FT_SHIFT 7

`endif

// ### rtl/ffpc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ffpc_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire pclk,
    input wire presetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    // full and empty come straight from the occupancy count
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_r[rd_ptr_r];
    assign level = cnt_r;

    // storage has no reset, only pointers and count do
    always @(posedge pclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap; depth is a power of two
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ### rtl/ffpc_core.v
// flat field pixel correction datapath with apb register file
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "ffpc_defs.vh"

module ffpc_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire pix_in_valid,
    output wire pix_in_ready,
    input wire pix_in_sof,
    input wire [11:0] pix_in_data,
    output wire pix_out_valid,
    input wire pix_out_ready,
    output wire [11:0] pix_out_data
);
    // control and coefficient state
    reg [`FFPC_CTRL_W-1:0] ctrl_r;
    reg [`FFPC_TBL_AW-1:0] caddr_r;
    reg [7:0] ft_a_r;
    reg [7:0] ft_b_r;
    reg [7:0] ft_c_r;
    reg sat_seen_r;
    reg [31:0] prdata_r;
    reg [15:0] coeff_mem [0:`FFPC_TBL_DEPTH-1];

    // stream state
    reg [`FFPC_TBL_AW-1:0] pix_idx_r;
    reg [11:0] prev1_r;
    reg [11:0] prev2_r;
    reg [11:0] prev3_r;

    wire setup_ph;
    wire access_ph;
    wire wr_acc;
    wire addr_ok;
    wire [`FFPC_FIFO_AW:0] fifo_level;
    wire fifo_in_ready;
    wire pix_take;
    wire [`FFPC_TBL_AW-1:0] cur_idx;
    wire [15:0] coeff_word;
    wire [6:0] pixel_offset_coeff;
    wire [8:0] pixel_gain_field;
    wire is_defect;
    wire ofs_en;
    wire gain_en;
    wire def_en;
    wire ft_en;
    wire [7:0] ft_wr_val;

    reg signed [13:0] diff_s;
    reg [11:0] ofs_stage;
    reg [10:0] pixel_gain_factor;
    reg [3:0] gain_shift;
    reg [22:0] gain_prod;
    reg [22:0] gain_scaled;
    reg [11:0] gain_stage;
    reg gain_sat;
    reg [11:0] def_stage;
    reg signed [23:0] ft_sum;
    reg signed [24:0] ft_total;
    reg [11:0] ft_stage;
    reg ft_sat;
    reg [31:0] rd_mux;

    // clamp a signed value into the output code range
    function [11:0] sat_pix;
        input signed [24:0] v;
        begin
            if (v < 0) begin
                sat_pix = 12'h000;
            end else if (v > $signed({13'h0000, `FFPC_PIX_MAX})) begin
                sat_pix = `FFPC_PIX_MAX;
            end else begin
                sat_pix = v[11:0];
            end
        end
    endfunction

    // signed coefficient times an unsigned pixel
    function signed [21:0] ft_mul;
        input [7:0] c;
        input [11:0] p;
        begin
            ft_mul = $signed(c) * $signed({1'b0, p});
        end
    endfunction

    // apb decode; the slave never inserts wait states
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign pready = 1'b1;
    assign wr_acc = access_ph & pwrite & addr_ok;
    assign pslverr = access_ph & ~addr_ok;
    assign prdata = prdata_r;

    // writes to read-only words are refused like unmapped ones
    assign addr_ok = (paddr == `FFPC_REG_CTRL) | (paddr == `FFPC_REG_CADDR)
        | (paddr == `FFPC_REG_CDATA) | (paddr == `FFPC_REG_FTA)
        | (paddr == `FFPC_REG_FTB) | (paddr == `FFPC_REG_FTC)
        | (paddr == `FFPC_REG_STAT)
        | (~pwrite & ((paddr == `FFPC_REG_OFSLO) | (paddr == `FFPC_REG_OFSHI)
        | (paddr == `FFPC_REG_GAINHI) | (paddr == `FFPC_REG_GAINLO)
        | (paddr == `FFPC_REG_OFSMUL) | (paddr == `FFPC_REG_GDIV)));

    // -128 is folded to -127 so the stored range stays symmetric
    assign ft_wr_val = (pwdata[7:0] == `FFPC_FT_NEG_MIN) ? `FFPC_FT_NEG_LIM : pwdata[7:0];

    // read data is captured at the end of setup, ready in access
    always @* begin
        rd_mux = 32'h00000000;
        case (paddr)
            `FFPC_REG_CTRL: rd_mux = {26'h0000000, ctrl_r};
            `FFPC_REG_CADDR: rd_mux = {24'h000000, caddr_r};
            `FFPC_REG_CDATA: rd_mux = {16'h0000, coeff_mem[caddr_r]};
            `FFPC_REG_FTA: rd_mux = {{24{ft_a_r[7]}}, ft_a_r};
            `FFPC_REG_FTB: rd_mux = {{24{ft_b_r[7]}}, ft_b_r};
            `FFPC_REG_FTC: rd_mux = {{24{ft_c_r[7]}}, ft_c_r};
            `FFPC_REG_OFSLO: rd_mux = `FFPC_OFS_LO;
            `FFPC_REG_OFSHI: rd_mux = `FFPC_OFS_HI;
            `FFPC_REG_GAINHI: rd_mux = `FFPC_GAIN_HI;
            `FFPC_REG_GAINLO: rd_mux = `FFPC_GAIN_LO;
            `FFPC_REG_OFSMUL: rd_mux = `FFPC_OFS_MUL;
            `FFPC_REG_GDIV: rd_mux = `FFPC_GDIV_REPORT;
            `FFPC_REG_STAT: rd_mux = {20'h00000, fifo_level, 7'h00, sat_seen_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // register writes; the coefficient port auto-increments
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `FFPC_CTRL_RST;
            caddr_r <= {`FFPC_TBL_AW{1'b0}};
            ft_a_r <= 8'h00;
            ft_b_r <= 8'h00;
            ft_c_r <= 8'h00;
            prdata_r <= 32'h00000000;
        end else begin
            if (setup_ph & ~pwrite) begin
                prdata_r <= rd_mux;
            end
            if (wr_acc) begin
                case (paddr)
                    `FFPC_REG_CTRL: ctrl_r <= pwdata[`FFPC_CTRL_W-1:0];
                    `FFPC_REG_CADDR: caddr_r <= pwdata[`FFPC_TBL_AW-1:0];
                    `FFPC_REG_CDATA: caddr_r <= caddr_r + 1'b1;
                    `FFPC_REG_FTA: ft_a_r <= ft_wr_val;
                    `FFPC_REG_FTB: ft_b_r <= ft_wr_val;
                    `FFPC_REG_FTC: ft_c_r <= ft_wr_val;
                    default: ctrl_r <= ctrl_r;
                endcase
            end
        end
    end

    // one coefficient word per pixel, no reset on the table
    always @(posedge pclk) begin
        if (wr_acc & (paddr == `FFPC_REG_CDATA)) begin
            coeff_mem[caddr_r] <= pwdata[15:0];
        end
    end

    // saturation flag: a new event wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_seen_r <= 1'b0;
        end else if (pix_take & (gain_sat | ft_sat)) begin
            sat_seen_r <= 1'b1;
        end else if (wr_acc & (paddr == `FFPC_REG_STAT) & pwdata[`FFPC_STAT_SAT]) begin
            sat_seen_r <= 1'b0;
        end
    end

    // stage enables, each independent of the others
    assign ofs_en = ctrl_r[`FFPC_CTRL_OFS_EN];
    assign gain_en = ctrl_r[`FFPC_CTRL_GAIN_EN];
    assign def_en = ctrl_r[`FFPC_CTRL_DEF_EN];
    assign ft_en = ctrl_r[`FFPC_CTRL_FT_EN];

    // a pixel is taken only while the output fifo has room
    assign pix_in_ready = fifo_in_ready;
    assign pix_take = pix_in_valid & fifo_in_ready;
    assign cur_idx = pix_in_sof ? {`FFPC_TBL_AW{1'b0}} : pix_idx_r;
    assign coeff_word = coeff_mem[cur_idx];
    assign pixel_offset_coeff = coeff_word[`FFPC_OFS_MSB:0];
    assign pixel_gain_field = coeff_word[`FFPC_GAIN_MSB:`FFPC_GAIN_LSB];
    // an offset code above the valid maximum marks a defective pixel
    assign is_defect = (pixel_offset_coeff == `FFPC_DEFECT_MARK);

    // offset stage: multiplier 1.0, negative differences clamp to zero
    always @* begin
        diff_s = $signed({2'b00, pix_in_data}) - $signed({7'h00, pixel_offset_coeff});
        if (!ofs_en) begin
            ofs_stage = pix_in_data;
        end else if (diff_s < 0) begin
            ofs_stage = 12'h000;
        end else begin
            ofs_stage = diff_s[11:0];
        end
    end

    // gain stage: (divisor + raw) * x / divisor == x * (raw/div + 1)
    always @* begin
        if (ctrl_r[`FFPC_CTRL_GRES]) begin
            pixel_gain_factor = `FFPC_BASE_HR + {2'b00, pixel_gain_field};
            gain_shift = `FFPC_SHIFT_HR;
        end else begin
            pixel_gain_factor = `FFPC_BASE_HG + {2'b00, pixel_gain_field};
            gain_shift = `FFPC_SHIFT_HG;
        end
        gain_prod = ofs_stage * pixel_gain_factor;
        gain_scaled = gain_prod >> gain_shift;
        gain_sat = gain_en & (gain_scaled > {11'h000, `FFPC_PIX_MAX});
        if (!gain_en) begin
            gain_stage = ofs_stage;
        end else if (gain_sat) begin
            gain_stage = `FFPC_PIX_MAX;
        end else begin
            gain_stage = gain_scaled[11:0];
        end
    end

    // defect stage: nearest preceding corrected pixel stands in
    always @* begin
        if (def_en & is_defect & ~pix_in_sof) begin
            def_stage = prev1_r;
        end else if (def_en & is_defect) begin
            def_stage = 12'h000;
        end else begin
            def_stage = gain_stage;
        end
    end

    // feedthrough stage: weighted earlier pixels, scaled by 1/128
    // the last frame's history must not leak into the first pixel
    always @* begin
        if (pix_in_sof) begin
            ft_sum = 24'sh000000;
        end else begin
            ft_sum = ft_mul(ft_a_r, prev1_r) + ft_mul(ft_b_r, prev2_r)
                + ft_mul(ft_c_r, prev3_r);
        end
        ft_total = $signed({13'h0000, def_stage}) + (ft_sum >>> `FFPC_FT_SHIFT);
        ft_sat = ft_en & ((ft_total < 0) | (ft_total > $signed({13'h0000, `FFPC_PIX_MAX})));
        if (ft_en) begin
            ft_stage = sat_pix(ft_total);
        end else begin
            ft_stage = def_stage;
        end
    end

    // pixel position and neighbour history; start of frame restarts the position and clears prev2_r and prev3_r
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_idx_r <= {`FFPC_TBL_AW{1'b0}};
            prev1_r <= 12'h000;
            prev2_r <= 12'h000;
            prev3_r <= 12'h000;
        end else if (pix_take) begin
            pix_idx_r <= cur_idx + 1'b1;
            prev1_r <= def_stage;
            prev2_r <= pix_in_sof ? 12'h000 : prev1_r;
            prev3_r <= pix_in_sof ? 12'h000 : prev2_r;
        end
    end

    // output fifo absorbs downstream stalls
    ffpc_fifo #(
        .WIDTH(`FFPC_PIX_W),
        .DEPTH(`FFPC_FIFO_DEPTH),
        .AW(`FFPC_FIFO_AW)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(pix_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(ft_stage),
        .out_valid(pix_out_valid),
        .out_ready(pix_out_ready),
        .out_data(pix_out_data),
        .level(fifo_level)
    );
endmodule

// ### dv/ffpc_chk.sv
// assertion checker for the correction core's bus and output ports
`timescale 1ns/1ps
`include "ffpc_defs.vh"
module ffpc_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire pix_out_valid,
    input wire pix_out_ready,
    input wire [11:0] pix_out_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase qualifiers
    wire rd_acc = psel && penable && !pwrite;
    wire wr_acc = psel && penable && pwrite;
    a_ofs_lo_read: assert property (
        rd_acc && paddr == `FFPC_REG_OFSLO |-> prdata == `FFPC_OFS_LO)
        else $error("offset lower limit misread");
    a_ofs_hi_read: assert property (
        rd_acc && paddr == `FFPC_REG_OFSHI |-> prdata == `FFPC_OFS_HI)
        else $error("offset upper limit misread");
    a_gain_hi_read: assert property (
        rd_acc && paddr == `FFPC_REG_GAINHI |-> prdata == `FFPC_GAIN_HI)
        else $error("gain upper limit misread");
    a_gain_lo_read: assert property (
        rd_acc && paddr == `FFPC_REG_GAINLO |-> prdata == `FFPC_GAIN_LO)
        else $error("gain lower limit misread");
    a_ofs_mul_read: assert property (
        rd_acc && paddr == `FFPC_REG_OFSMUL |-> prdata == `FFPC_OFS_MUL)
        else $error("offset multiplier misread");
    a_gdiv_read: assert property (
        rd_acc && paddr == `FFPC_REG_GDIV |-> prdata == `FFPC_GDIV_REPORT)
        else $error("gain divisor misread");
    // -128 is outside the legal range, so its pattern must never read back
    a_ft_in_range: assert property (
        rd_acc && paddr >= `FFPC_REG_FTA && paddr <= `FFPC_REG_FTC |->
        prdata[31:7] == {25{prdata[7]}} && prdata != 32'hffffff80)
        else $error("feedthrough value out of range");
    a_ro_write_err: assert property (
        wr_acc && paddr >= `FFPC_REG_OFSLO && paddr <= `FFPC_REG_GDIV
        && paddr[1:0] == 2'h0 |-> pslverr)
        else $error("read-only write not refused");
    a_out_hold: assert property (
        pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out_data))
        else $error("stalled output pixel changed");
endmodule

bind ffpc_core ffpc_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pslverr(pslverr),
    .pix_out_valid(pix_out_valid),
    .pix_out_ready(pix_out_ready),
    .pix_out_data(pix_out_data)
);

// ### dv/ffpc_sink.sv
// downstream image output model with random and forced stalls
`timescale 1ns/1ps
module ffpc_sink (
    input wire pclk,
    input wire presetn,
    input wire hold,
    output reg pix_out_ready
);
    integer seed = 12768;
    // ready drops about a quarter of cycles so the fifo really backs up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_out_ready <= 1'b0;
        end else begin
            pix_out_ready <= !hold && (($random(seed) & 3) != 0);
        end
    end
endmodule

// ### dv/test_flat_field_pixel_correction.sv
// self-checking bench for the flat field pixel correction core
`timescale 1ns/1ps
`include "ffpc_defs.vh"
module test_flat_field_pixel_correction;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg pix_in_valid = 0, pix_in_sof = 0;
    reg [11:0] pix_in_data = 0;
    wire [31:0] prdata;
    wire pready, pslverr, pix_in_ready, pix_out_valid, pix_out_ready;
    wire [11:0] pix_out_data;
    integer seed = 12768, bad_count = 0, tests_run = 0;
    integer fa, fb, fc, h1, h2, h3, i, m;
    integer sat_exp = 0;
    reg [5:0] ctrl;
    reg [15:0] coef [0:15];
    reg [33:0] rq [$];
    reg [11:0] pq [$];
    reg [33:0] e;
    reg [5:0] modes [0:7] = '{6'h01, 6'h02, 6'h03, 6'h13, 6'h00, 6'h07, 6'h0f, 6'h3f};
    reg [31:0] ro [0:5] = '{`FFPC_OFS_LO, `FFPC_OFS_HI, `FFPC_GAIN_HI, `FFPC_GAIN_LO,
        `FFPC_OFS_MUL, `FFPC_GDIV_REPORT};

    always #25 pclk = ~pclk;

    ffpc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .pix_in_sof(pix_in_sof), .pix_in_data(pix_in_data),
        .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
        .pix_out_data(pix_out_data));
    ffpc_sink u_sink (.pclk(pclk), .presetn(presetn), .hold(hold),
        .pix_out_ready(pix_out_ready));

    task cmp_reg(input [32:0] g, input [32:0] x);
        tests_run = tests_run + 1;
        if (g !== x) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task cmp_pix(input [11:0] g, input [11:0] x);
        tests_run = tests_run + 1;
        if (g !== x) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task tally_and_finish;
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one apb transfer; x holds {check data, error, data} for the monitor
    task apb(input w, input [7:0] a, input [31:0] d, input [33:0] x);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        rq.push_back(x);
        do @(posedge pclk); while (!pready);
        psel <= 0; penable <= 0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1, a, d, 34'h0);
    endtask
    task rd(input [7:0] a, input [31:0] d);
        apb(0, a, 32'h0, {2'b10, d});
    endtask
    task drain;
        integer k;
        for (k = 0; k < 500 && pq.size() > 0; k = k + 1) @(posedge pclk);
        // results still owed after the limit count as a mismatch
        if (pq.size() > 0) begin
            bad_count = bad_count + 1;
        end
    endtask

    // stream a frame; expectation follows offset, gain, defect and feedthrough stages
    task send_frame(input integer len);
        integer n, px, d, g, v, o;
        @(posedge pclk);
        for (n = 0; n < len; n = n + 1) begin
            px = $random(seed) & (n[0] ? 12'hfff : 12'h07f);
            if (n == 0) begin
                h1 = 0; h2 = 0; h3 = 0;
            end
            d = ctrl[0] ? (px > coef[n][6:0] ? px - coef[n][6:0] : 0) : px;
            g = ctrl[1] ? (d * ((ctrl[4] ? 1024 : 512) + coef[n][15:7])) >>> (ctrl[4] ? 10 : 9)
                : d;
            if (ctrl[1] && g > 4095) sat_exp = 1;
            if (g > 4095) g = 4095;
            v = (ctrl[2] && coef[n][6:0] == 7'h7f) ? h1 : g;
            o = ctrl[3] ? v + ((fa * h1 + fb * h2 + fc * h3) >>> 7) : v;
            if (ctrl[3] && (o < 0 || o > 4095)) sat_exp = 1;
            o = o < 0 ? 0 : (o > 4095 ? 4095 : o);
            h3 = h2; h2 = h1; h1 = v;
            pix_in_valid <= 1; pix_in_sof <= (n == 0); pix_in_data <= px;
            do @(posedge pclk); while (!pix_in_ready);
            pq.push_back(o);
        end
        pix_in_valid <= 0;
    endtask

    // result monitor: pops the oldest note whenever a result shows
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready) begin
            e = rq.size() ? rq.pop_front() : 34'hx;
            cmp_reg({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
        end
        if (presetn && pix_out_valid && pix_out_ready) begin
            cmp_pix(pix_out_data, pq.size() ? pq.pop_front() : 12'hx);
        end
    end

    initial begin
        #(50 * 20000);
        bad_count = bad_count + 1;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        rd(`FFPC_REG_CTRL, 32'h3);
        rd(`FFPC_REG_CADDR, 32'h0);
        rd(`FFPC_REG_FTA, 32'h0);
        for (i = 0; i < 6; i = i + 1) rd(8'h18 + 4 * i, ro[i]);
        apb(1, `FFPC_REG_OFSLO, 32'h5, {2'b01, 32'h0});
        apb(0, 8'h40, 32'h0, {2'b01, 32'h0});
        // per-pixel coefficient words, one forced defect marker
        wr(`FFPC_REG_CADDR, 32'h0);
        for (i = 0; i < 16; i = i + 1) begin
            coef[i] = (i == 5) ? {$random(seed), 7'h7f} : $random(seed);
            wr(`FFPC_REG_CDATA, coef[i]);
        end
        wr(`FFPC_REG_CADDR, 32'h0);
        rd(`FFPC_REG_CDATA, coef[0]);
        fa = $random(seed) % 128;
        fb = $random(seed) % 128;
        fc = -127;
        wr(`FFPC_REG_FTA, fa);
        wr(`FFPC_REG_FTB, fb);
        wr(`FFPC_REG_FTC, 32'hffffff80);
        rd(`FFPC_REG_FTA, fa);
        rd(`FFPC_REG_FTC, 32'hffffff81);
        // eight modes covering six of the sixteen stage combinations, both gain resolutions
        for (m = 0; m < 8; m = m + 1) begin
            ctrl = modes[m];
            wr(`FFPC_REG_CTRL, ctrl);
            send_frame(16);
        end
        // fill the output buffer with the sink stalled until it refuses
        drain;
        hold <= 1;
        @(posedge pclk);
        send_frame(8);
        #1;
        cmp_pix({11'h0, pix_in_ready}, 12'h0);
        hold <= 0;
        drain;
        // buffer is empty now, so only the saturation flag may show
        rd(`FFPC_REG_STAT, sat_exp);
        wr(`FFPC_REG_STAT, 32'h1);
        rd(`FFPC_REG_STAT, 32'h0);
        tally_and_finish;
    end
endmodule
